// file: rtl/bmm_pkg.sv
// Constants and types shared by the banked memory map files
package bmm_pkg;
  localparam int PC_W          = 13;
  localparam int PROG_AW       = 11;
  localparam int PROG_DW       = 14;
  localparam int DATA_W        = 8;
  localparam int OFF_W         = 7;
  localparam int FADDR_W       = 9;
  localparam int RAM_AW        = 7;
  localparam int LATCH_USED_W  = 5;
  localparam int BANK_HI_BIT   = 6;
  localparam int BANK_LO_BIT   = 5;
  localparam int IND_BANK_BIT  = 7;

  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_VECTOR   = 13'h0004;

  localparam logic [OFF_W-1:0] OFF_INDIRECT            = 7'h00;
  localparam logic [OFF_W-1:0] OFF_PC_LOW_BYTE         = 7'h02;
  localparam logic [OFF_W-1:0] OFF_STATUS              = 7'h03;
  localparam logic [OFF_W-1:0] OFF_FILE_SELECT_POINTER = 7'h04;
  localparam logic [OFF_W-1:0] OFF_GAP_A               = 7'h05;
  localparam logic [OFF_W-1:0] OFF_GAP_C               = 7'h07;
  localparam logic [OFF_W-1:0] OFF_PORTD               = 7'h08;
  localparam logic [OFF_W-1:0] OFF_PORTE               = 7'h09;
  localparam logic [OFF_W-1:0] OFF_PC_UPPER_LATCH      = 7'h0A;
  localparam logic [OFF_W-1:0] OFF_INTERRUPT_CONTROL   = 7'h0B;
  localparam logic [OFF_W-1:0] OFF_HI_SFR              = 7'h10;
  localparam logic [OFF_W-1:0] GPR_BASE                = 7'h20;
  localparam logic [OFF_W-1:0] BANK1_GPR_END           = 7'h3F;
  localparam logic [OFF_W-1:0] SHARED_BASE             = 7'h70;
  localparam logic [OFF_W-1:0] BANK1_RAM_SHIFT         = 7'h40;

  localparam logic [OFF_W-1:0] IDX_PROG_ADDR = 7'h40;
  localparam logic [OFF_W-1:0] IDX_PROG_DATA = 7'h41;

  localparam logic [DATA_W-1:0] STATUS_RST              = 8'h00;
  localparam logic [DATA_W-1:0] FILE_SELECT_POINTER_RST = 8'h00;
  localparam logic [DATA_W-1:0] PC_UPPER_LATCH_RST      = 8'h00;
  localparam logic [DATA_W-1:0] INTERRUPT_CONTROL_RST   = 8'h00;

  typedef enum logic [8:0] {
    BMM_REG_IND                 = 9'h001,
    BMM_REG_PC_LOW_BYTE         = 9'h002,
    BMM_REG_STATUS              = 9'h004,
    BMM_REG_FILE_SELECT_POINTER = 9'h008,
    BMM_REG_PC_UPPER_LATCH      = 9'h010,
    BMM_REG_INTERRUPT_CONTROL   = 9'h020,
    BMM_REG_RAM                 = 9'h040,
    BMM_REG_PERIPH              = 9'h080,
    BMM_REG_NONE                = 9'h100
  } bmm_region_e;

  typedef struct packed {
    logic              we;
    logic [OFF_W-1:0]  offset;
    logic [DATA_W-1:0] wdata;
  } bmm_file_cmd_s;

  typedef struct packed {
    logic               we;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0]  wdata;
  } bmm_periph_s;
endpackage

// file: rtl/bmm_mem.sv
// Simple dual-port memory with registered read data
`timescale 1ns/1ns
module bmm_mem #(
  parameter int DW = 8,
  parameter int AW = 7
) (
  input  wire logic          pclk,    // Core clock
  input  wire logic          presetn, // Async reset, active low
  input  wire logic          we,      // Write strobe
  input  wire logic [AW-1:0] waddr,   // Write address
  input  wire logic [DW-1:0] wdata,   // Write data
  input  wire logic [AW-1:0] raddr,   // Read address
  output logic      [DW-1:0] rdata    // Read data, one cycle later
);
  logic [DW-1:0] store [2**AW];

  always_ff @(posedge pclk) begin
    if (we) begin
      store[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= store[raddr];
    end
  end
endmodule

// file: rtl/bmm_decode.sv
// File address decoder for the four data banks
`timescale 1ns/1ns
module bmm_decode
  import bmm_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b1
) (
  input  wire logic [bmm_pkg::FADDR_W-1:0] file_addr, // Bank and offset
  output bmm_pkg::bmm_region_e             region,    // Target kind
  output logic      [bmm_pkg::RAM_AW-1:0]  ram_idx    // Physical RAM byte
);
  logic [OFF_W-1:0] off;
  logic [1:0]       bank;

  assign off  = file_addr[OFF_W-1:0];
  assign bank = file_addr[FADDR_W-1:OFF_W];

  always_comb begin
    region  = BMM_REG_NONE;
    ram_idx = '0;
    if (off >= SHARED_BASE) begin
      region  = BMM_REG_RAM;                          // [RL12]
      ram_idx = RAM_AW'(off - GPR_BASE);
    end else if (off >= GPR_BASE) begin
      if (!bank[0]) begin
        region  = BMM_REG_RAM;                        // [RL7] [RL12]
        ram_idx = RAM_AW'(off - GPR_BASE);
      end else if (off <= BANK1_GPR_END) begin
        region  = BMM_REG_RAM;                        // [RL7] [RL12]
        ram_idx = RAM_AW'(off + BANK1_RAM_SHIFT);
      end
    end else begin
      case (off)
        OFF_INDIRECT:            region = BMM_REG_IND;                 // [RL9]
        OFF_PC_LOW_BYTE:         region = BMM_REG_PC_LOW_BYTE;         // [RL8]
        OFF_STATUS:              region = BMM_REG_STATUS;              // [RL8]
        OFF_FILE_SELECT_POINTER: region = BMM_REG_FILE_SELECT_POINTER; // [RL8]
        OFF_PC_UPPER_LATCH:      region = BMM_REG_PC_UPPER_LATCH;      // [RL8]
        OFF_INTERRUPT_CONTROL:   region = BMM_REG_INTERRUPT_CONTROL;   // [RL8]
        OFF_PORTD, OFF_PORTE: begin
          region = (SMALL_VARIANT || bank[1]) ? BMM_REG_NONE : BMM_REG_PERIPH; // [RL11]
        end
        default: begin
          if (bank[1] && (off == OFF_GAP_A || off == OFF_GAP_C || off >= OFF_HI_SFR)) begin
            region = BMM_REG_NONE;
          end else begin
            region = BMM_REG_PERIPH;                  // [RL7]
          end
        end
      endcase
    end
  end
endmodule

// file: rtl/bmm_top.sv
// Program and data memory map with shared core registers and APB access
`timescale 1ns/1ns
// How it works
// (RL1) Fetch and file access use separate memories
// (RL2) Thirteen-bit program counter, 8K word space
// (RL3) Only 2K words stored; upper bits ignored
// (RL4) Reset starts at zero; interrupt loads four
// (RL5) Two status bits pick the direct bank
// (RL6) Bank bits join seven-bit offset
// (RL7) Low offsets are registers, above is RAM; banks 1 and 3 leave offsets 40h-6Fh unmapped
// (RL8) Core registers mirrored in all four banks
// (RL9) Offset zero reaches file through pointer
// (RL10) Software keeps reserved bank 3 locations clear
// (RL11) Small variant lacks ports D and E
// (RL12) Shared top sixteen bytes, upper banks alias
module bmm_top
  import bmm_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b1
) (
  input  wire logic                         pclk,         // Core clock, 100 MHz
  input  wire logic                         presetn,      // Async reset, active low
  input  wire logic                         psel,         // APB select
  input  wire logic                         penable,      // APB enable
  input  wire logic                         pwrite,       // APB direction
  input  wire logic [11:0]                  paddr,        // APB byte address
  input  wire logic [31:0]                  pwdata,       // APB write data
  output logic      [31:0]                  prdata,       // APB read data
  output logic                              pready,       // APB ready
  output logic                              pslverr,      // APB error
  input  wire logic                         pc_advance,   // Step the counter
  input  wire logic                         irq_take,     // Interrupt taken
  output logic      [bmm_pkg::PROG_DW-1:0]  fetch_word,   // Fetched instruction
  output logic      [bmm_pkg::PC_W-1:0]     fetch_pc,     // Address of fetch_word
  input  wire logic                         file_req,     // File access request
  input  wire bmm_pkg::bmm_file_cmd_s       file_cmd,     // Direction, offset, data
  output logic                              file_ack,     // Access answered
  output logic      [bmm_pkg::DATA_W-1:0]   file_rdata,   // Read data
  output logic                              periph_strobe, // Peripheral access
  output bmm_pkg::bmm_periph_s              periph_cmd,   // Peripheral request
  input  wire logic [bmm_pkg::DATA_W-1:0]   periph_rdata  // Peripheral read data
);
  import bmm_pkg::*;

  logic [PC_W-1:0]    pc_r;
  logic [DATA_W-1:0]  status_r;
  logic [DATA_W-1:0]  file_select_pointer_r;
  logic [DATA_W-1:0]  pc_upper_latch_r;
  logic [DATA_W-1:0]  interrupt_control_r;
  logic [PROG_AW-1:0] prog_addr_r;
  logic [PROG_AW-1:0] prog_raddr;
  logic [FADDR_W-1:0] eff_addr;
  bmm_region_e        region;
  logic [RAM_AW-1:0]  ram_idx;
  logic [DATA_W-1:0]  ram_rdata;
  logic [DATA_W-1:0]  sfr_val;
  logic               core_wr;
  logic               apb_done;
  logic               apb_wr;
  logic               apb_aligned;
  logic [OFF_W-1:0]   apb_idx;
  logic [31:0]        apb_rd;
  logic               apb_hit;
  logic               pc_low_load;
  logic [PC_W-1:0]    pc_low_target;
  logic               req1_r;
  bmm_region_e        kind1_r;
  logic [DATA_W-1:0]  sfr1_r;

  // Effective file address: direct bank plus offset, or pointer when offset is zero
  assign eff_addr = (file_cmd.offset != OFF_INDIRECT) ?
                    {status_r[BANK_HI_BIT], status_r[BANK_LO_BIT], file_cmd.offset} : // [RL5] [RL6]
                    {status_r[IND_BANK_BIT], file_select_pointer_r};                 // [RL9]

  bmm_decode #(
    .SMALL_VARIANT (SMALL_VARIANT)
  ) u_decode (
    .file_addr (eff_addr),
    .region    (region),
    .ram_idx   (ram_idx)
  );

  // Data RAM on its own port, independent of the fetch memory
  bmm_mem #(
    .DW (DATA_W),
    .AW (RAM_AW)
  ) u_data_ram (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (core_wr && region == BMM_REG_RAM), // [RL1] [RL7]
    .waddr   (ram_idx),
    .wdata   (file_cmd.wdata),
    .raddr   (ram_idx),
    .rdata   (ram_rdata)
  );

  assign prog_raddr = pc_r[PROG_AW-1:0];                 // [RL3]

  bmm_mem #(
    .DW (PROG_DW),
    .AW (PROG_AW)
  ) u_prog_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (apb_wr && apb_idx == IDX_PROG_DATA),
    .waddr   (prog_addr_r),
    .wdata   (pwdata[PROG_DW-1:0]),
    .raddr   (prog_raddr),                               // [RL1]
    .rdata   (fetch_word)
  );

  assign core_wr     = file_req && file_cmd.we;
  assign apb_done    = psel && penable && pready;
  assign apb_aligned = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0);
  assign apb_idx     = paddr[8:2];
  assign apb_wr      = apb_done && pwrite && apb_aligned;

  // Counter loads from a low byte write, core write taking priority over APB
  always_comb begin
    pc_low_load   = 1'b0;
    pc_low_target = pc_r;
    if (core_wr && region == BMM_REG_PC_LOW_BYTE) begin
      pc_low_load   = 1'b1;
      pc_low_target = {pc_upper_latch_r[LATCH_USED_W-1:0], file_cmd.wdata}; // [RL8]
    end else if (apb_wr && apb_idx == OFF_PC_LOW_BYTE) begin
      pc_low_load   = 1'b1;
      pc_low_target = {pc_upper_latch_r[LATCH_USED_W-1:0], pwdata[DATA_W-1:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= RESET_VECTOR;                              // [RL4]
    end else if (irq_take) begin
      pc_r <= IRQ_VECTOR;                                // [RL4]
    end else if (pc_low_load) begin
      pc_r <= pc_low_target;
    end else if (pc_advance) begin
      pc_r <= PC_W'(pc_r + 13'h0001);                    // [RL2]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_pc <= RESET_VECTOR;
    end else begin
      fetch_pc <= pc_r;
    end
  end

  // One physical copy of each mirrored register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= STATUS_RST;
    end else if (core_wr && region == BMM_REG_STATUS) begin
      status_r <= file_cmd.wdata;                        // [RL8]
    end else if (apb_wr && apb_idx == OFF_STATUS) begin
      status_r <= pwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_select_pointer_r <= FILE_SELECT_POINTER_RST;
    end else if (core_wr && region == BMM_REG_FILE_SELECT_POINTER) begin
      file_select_pointer_r <= file_cmd.wdata;           // [RL8]
    end else if (apb_wr && apb_idx == OFF_FILE_SELECT_POINTER) begin
      file_select_pointer_r <= pwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_upper_latch_r <= PC_UPPER_LATCH_RST;
    end else if (core_wr && region == BMM_REG_PC_UPPER_LATCH) begin
      pc_upper_latch_r <= file_cmd.wdata;                // [RL8]
    end else if (apb_wr && apb_idx == OFF_PC_UPPER_LATCH) begin
      pc_upper_latch_r <= pwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_control_r <= INTERRUPT_CONTROL_RST;
    end else if (core_wr && region == BMM_REG_INTERRUPT_CONTROL) begin
      interrupt_control_r <= file_cmd.wdata;             // [RL8]
    end else if (apb_wr && apb_idx == OFF_INTERRUPT_CONTROL) begin
      interrupt_control_r <= pwdata[DATA_W-1:0];
    end
  end

  // Program load pointer, steps after each data write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_addr_r <= '0;
    end else if (apb_wr && apb_idx == IDX_PROG_ADDR) begin
      prog_addr_r <= pwdata[PROG_AW-1:0];
    end else if (apb_wr && apb_idx == IDX_PROG_DATA) begin
      prog_addr_r <= PROG_AW'(prog_addr_r + 11'h001);
    end
  end

  always_comb begin
    case (region)
      BMM_REG_PC_LOW_BYTE:         sfr_val = pc_r[DATA_W-1:0]; // [RL8]
      BMM_REG_STATUS:              sfr_val = status_r;
      BMM_REG_FILE_SELECT_POINTER: sfr_val = file_select_pointer_r;
      BMM_REG_PC_UPPER_LATCH:      sfr_val = pc_upper_latch_r;
      BMM_REG_INTERRUPT_CONTROL:   sfr_val = interrupt_control_r;
      default:        sfr_val = '0;                      // [RL9] [RL11]
    endcase
  end

  // File read pipeline: capture at request, answer two edges later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req1_r  <= 1'b0;
      kind1_r <= BMM_REG_NONE;
      sfr1_r  <= '0;
    end else begin
      req1_r  <= file_req;
      kind1_r <= region;
      sfr1_r  <= sfr_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_strobe <= 1'b0;
      periph_cmd    <= '0;
    end else begin
      periph_strobe <= file_req && region == BMM_REG_PERIPH; // [RL11]
      periph_cmd    <= '{we: file_cmd.we, addr: eff_addr, wdata: file_cmd.wdata};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_ack   <= 1'b0;
      file_rdata <= '0;
    end else begin
      file_ack <= req1_r;
      if (req1_r) begin
        case (kind1_r)
          BMM_REG_RAM:    file_rdata <= ram_rdata;
          BMM_REG_PERIPH: file_rdata <= periph_rdata;
          default:        file_rdata <= sfr1_r;
        endcase
      end
    end
  end

  // APB read mux
  always_comb begin
    apb_hit = 1'b1;
    case (apb_idx)
      OFF_INDIRECT:  apb_rd = 32'h0000_0000;
      OFF_PC_LOW_BYTE:         apb_rd = {24'h00_0000, pc_r[DATA_W-1:0]};
      OFF_STATUS:              apb_rd = {24'h00_0000, status_r};
      OFF_FILE_SELECT_POINTER: apb_rd = {24'h00_0000, file_select_pointer_r};
      OFF_PC_UPPER_LATCH:      apb_rd = {24'h00_0000, pc_upper_latch_r};
      OFF_INTERRUPT_CONTROL:   apb_rd = {24'h00_0000, interrupt_control_r};
      IDX_PROG_ADDR: apb_rd = {21'h00_0000, prog_addr_r};
      IDX_PROG_DATA: apb_rd = 32'h0000_0000;
      default: begin
        apb_rd  = 32'h0000_0000;
        apb_hit = 1'b0;
      end
    endcase
  end

  // One wait state on every access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata  <= (apb_hit && apb_aligned) ? apb_rd : 32'h0000_0000;
        pslverr <= !(apb_hit && apb_aligned);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_status_read;
    file_req && !file_cmd.we && file_cmd.offset == OFF_STATUS;
  endsequence

  sequence s_status_answer;
    ##2 (file_ack && file_rdata == $past(status_r, 2));
  endsequence

  a_status_mirror: assert property (s_status_read |-> s_status_answer) // [RL8]
    else $error("status read in some bank did not return the shared register");

  a_irq_vector: assert property (irq_take |=> pc_r == IRQ_VECTOR) // [RL4]
    else $error("interrupt did not load the interrupt vector");

  a_pc_step_wrap: assert property (pc_advance && !irq_take && !pc_low_load // [RL2]
                                   |=> pc_r == PC_W'($past(pc_r) + 13'h0001))
    else $error("program counter did not step by one");

  // Fetch keeps tracking the counter while a file access is in flight
  a_fetch_follows: assert property (file_req |=> fetch_pc == $past(pc_r)) // [RL1]
    else $error("fetch address did not follow the counter");

  a_indirect_route: assert property (file_req && file_cmd.offset == OFF_INDIRECT // [RL9]
    |-> eff_addr == {status_r[IND_BANK_BIT], file_select_pointer_r})
    else $error("offset zero did not route through the pointer");

  a_bank_direct: assert property (file_req && file_cmd.offset != OFF_INDIRECT // [RL5]
                                  |-> eff_addr[8:7] == status_r[6:5] &&
                                      eff_addr[6:0] == file_cmd.offset)
    else $error("direct bank does not match the status bank bits");

  a_shared_ram: assert property (file_req && eff_addr[6:4] == 3'h7 // [RL12]
                                 |-> region == BMM_REG_RAM && ram_idx == {3'h5, eff_addr[3:0]})
    else $error("top sixteen offsets did not reach the shared bytes");

  a_gpr_bank0: assert property (file_req && !eff_addr[7] && eff_addr[6:5] != 2'h0 // [RL7]
                                |-> region == BMM_REG_RAM && ram_idx == 7'(eff_addr[6:0] - 7'h20))
    else $error("general purpose offset mapped to the wrong RAM byte");

  a_absent_zero: assert property (file_req && !file_cmd.we && region == BMM_REG_NONE // [RL11]
                                  |-> ##2 (file_ack && file_rdata == 8'h00))
    else $error("absent location did not read as zero");

  a_absent_quiet: assert property (file_req && region == BMM_REG_NONE |=> !periph_strobe) // [RL11]
    else $error("absent location reached the peripheral port");

  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("APB access not answered after one wait state");
endmodule

// file: dv/bmm_core_model.sv
// Core-side stand-in: fetch control, file accesses, peripheral answers
`timescale 1ns/1ns
module bmm_core_model
  import bmm_pkg::*;
(
  input  wire logic                       pclk,          // Core clock
  output logic                            pc_advance,    // Counter step
  output logic                            irq_take,      // Interrupt taken
  output logic                            file_req,      // File request
  output bmm_pkg::bmm_file_cmd_s          file_cmd,      // File command
  input  wire logic                       file_ack,      // File answer
  input  wire logic [bmm_pkg::DATA_W-1:0] file_rdata,    // File read data
  input  wire logic                       periph_strobe, // Peripheral access
  input  wire bmm_pkg::bmm_periph_s       periph_cmd,    // Peripheral request
  output logic      [bmm_pkg::DATA_W-1:0] periph_rdata,  // Peripheral answer
  output int                              n_strobe,      // Peripheral accesses seen
  output bmm_pkg::bmm_periph_s            seen_cmd       // Last peripheral request
);
  logic [DATA_W-1:0] last_r;

  initial begin
    pc_advance = 1'b0;
    irq_take   = 1'b0;
    file_req   = 1'b0;
    file_cmd   = '0;
    last_r     = 8'h00;
    n_strobe   = 0;
    seen_cmd   = '0;
  end

  // Answer is the low eight bits of the file address XOR 5Ah; idle line shows a changing value
  assign periph_rdata = periph_strobe ? (periph_cmd.addr[7:0] ^ 8'h5A) : ~last_r;

  always @(posedge pclk) begin
    last_r   <= periph_rdata;
    n_strobe <= n_strobe + int'(periph_strobe);
    if (periph_strobe) begin
      seen_cmd <= periph_cmd;
    end
  end

  task automatic file_acc(input logic we, input logic [6:0] off, input logic [7:0] wd,
                          output logic [7:0] rd, output logic ok);
    int i;
    @(posedge pclk);
    file_req <= 1'b1;
    file_cmd <= '{we: we, offset: off, wdata: wd};
    @(posedge pclk);
    file_req <= 1'b0;
    ok = 1'b0;
    rd = 8'h00;
    for (i = 0; i < 8 && !ok; i++) begin
      @(posedge pclk);
      if (file_ack === 1'b1) begin
        ok = 1'b1;
        rd = file_rdata;
      end
    end
  endtask

  task automatic take_irq(input logic irq, input logic adv);
    @(posedge pclk);
    irq_take   <= irq;
    pc_advance <= adv;
    @(posedge pclk);
    irq_take   <= 1'b0;
    pc_advance <= 1'b0;
  endtask
endmodule

// file: dv/banked_memory_map_test.sv
// Self-checking bench for the banked memory map
`timescale 1ns/1ns
module banked_memory_map_test;
  import bmm_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic              pready, pslverr, pc_advance, irq_take, file_req, file_ack;
  logic              periph_strobe;
  logic [13:0]       fetch_word;
  logic [12:0]       fetch_pc;
  logic [7:0]        file_rdata, periph_rdata;
  bmm_file_cmd_s     file_cmd;
  bmm_periph_s       periph_cmd;
  bmm_periph_s       seen_cmd;
  int                n_strobe, n0, b;
  int                n_fail = 0;
  int                compares = 0;

  bmm_top #(.SMALL_VARIANT(1'b1)) bmm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pc_advance(pc_advance), .irq_take(irq_take),
    .fetch_word(fetch_word), .fetch_pc(fetch_pc), .file_req(file_req), .file_cmd(file_cmd),
    .file_ack(file_ack), .file_rdata(file_rdata), .periph_strobe(periph_strobe),
    .periph_cmd(periph_cmd), .periph_rdata(periph_rdata));

  bmm_core_model bmm_core_model_i (.pclk(pclk), .pc_advance(pc_advance),
    .irq_take(irq_take), .file_req(file_req), .file_cmd(file_cmd), .file_ack(file_ack),
    .file_rdata(file_rdata), .periph_strobe(periph_strobe), .periph_cmd(periph_cmd),
    .periph_rdata(periph_rdata), .n_strobe(n_strobe), .seen_cmd(seen_cmd));

  always #5 pclk = ~pclk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [6:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    logic got;
    got = 1'b0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {3'h0, idx, 2'h0};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16 && !got; i++) begin
      @(posedge pclk);
      got = (pready === 1'b1);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check("apb answer", got, 1'b1);
    if (!got) summarize();
  endtask

  task automatic wr(input logic [6:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, wd, rd, err);
    check("apb write error", err, 1'b0);
  endtask

  task automatic rdc(input string what, input logic [6:0] idx, input logic [31:0] exp,
                     input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 32'h0, rd, err);
    check(what, rd, exp);
    check("apb error flag", err, exp_err);
  endtask

  task automatic fa(input logic we, input logic [6:0] off, input logic [7:0] wd,
                    input logic [7:0] exp, input string what);
    logic [7:0] rd;
    logic       ok;
    bmm_core_model_i.file_acc(we, off, wd, rd, ok);
    check("file answer", ok, 1'b1);
    if (!ok) summarize();
    if (!we) check(what, rd, exp);
  endtask

  function automatic logic [13:0] pword(input int i);
    return 14'h2A00 + 14'(i);
  endfunction

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1 check("fetch_pc after reset", fetch_pc, 13'h0000);
    rdc("status reset", 7'h03, 32'h0, 1'b0);
    rdc("pointer reset", 7'h04, 32'h0, 1'b0);
    rdc("latch reset", 7'h0A, 32'h0, 1'b0);
    rdc("intctl reset", 7'h0B, 32'h0, 1'b0);
    wr(7'h04, 32'h0000_00A5);
    rdc("pointer", 7'h04, 32'h0000_00A5, 1'b0);
    wr(7'h0B, 32'h0000_003C);
    rdc("intctl", 7'h0B, 32'h0000_003C, 1'b0);
    rdc("indirect port", 7'h00, 32'h0, 1'b0);
    rdc("unmapped", 7'h7F, 32'h0, 1'b1);
    $display("test registers done");
    wr(7'h40, 32'h0);
    for (b = 0; b < 8; b++) wr(7'h41, {18'h0, pword(b)});
    rdc("load address", 7'h40, 32'h0000_0008, 1'b0);
    @(posedge pclk);
    #1 check("fetch word 0", fetch_word, pword(0));
    bmm_core_model_i.take_irq(1'b1, 1'b1);
    @(posedge pclk);
    #1 check("irq fetch_pc", fetch_pc, 13'h0004);
    check("irq fetch word", fetch_word, pword(4));
    bmm_core_model_i.take_irq(1'b0, 1'b1);
    @(posedge pclk);
    #1 check("advance fetch_pc", fetch_pc, 13'h0005);
    fork
      fa(1'b0, 7'h0B, 8'h0, 8'h3C, "fetch with file read");
      wr(7'h0A, 32'h0000_0008);
      bmm_core_model_i.take_irq(1'b0, 1'b1);
    join
    #1 check("fetch_pc during file read", fetch_pc, 13'h0006);
    check("fetch word during file read", fetch_word, pword(6));
    wr(7'h02, 32'h0000_0003);
    @(posedge pclk);
    #1 check("wrap fetch_pc", fetch_pc, 13'h0803);
    check("wrap fetch word", fetch_word, pword(3));
    fa(1'b1, 7'h02, 8'h01, 8'h0, "");
    #1 check("core low byte fetch_pc", fetch_pc, 13'h0801);
    check("core low byte fetch word", fetch_word, pword(1));
    $display("test program done");
    for (b = 0; b < 4; b++) begin
      fa(1'b1, 7'h03, 8'(b << 5), 8'h0, "");
      fa(1'b0, 7'h03, 8'h0, 8'(b << 5), "status mirror");
      fa(1'b1, 7'h25, 8'(8'h40 + b), 8'h0, "");
    end
    fa(1'b0, 7'h25, 8'h0, 8'h43, "bank3 ram");
    fa(1'b1, 7'h04, 8'h20, 8'h0, "");
    rdc("pointer via bank3", 7'h04, 32'h0000_0020, 1'b0);
    fa(1'b0, 7'h0C, 8'h0, 8'hD6, "bank3 peripheral addr");
    fa(1'b1, 7'h03, 8'h00, 8'h0, "");
    fa(1'b0, 7'h25, 8'h0, 8'h42, "bank0 ram");
    fa(1'b1, 7'h70, 8'h5A, 8'h0, "");
    fa(1'b1, 7'h03, 8'h60, 8'h0, "");
    fa(1'b0, 7'h70, 8'h0, 8'h5A, "shared top bytes");
    fa(1'b1, 7'h04, 8'h25, 8'h0, "");
    fa(1'b0, 7'h00, 8'h0, 8'h42, "indirect bank0");
    fa(1'b1, 7'h04, 8'hA5, 8'h0, "");
    fa(1'b0, 7'h00, 8'h0, 8'h43, "indirect bank1");
    $display("test banks done");
    // Bank 3 offsets 0Eh and 0Fh are never written here
    fa(1'b1, 7'h03, 8'h00, 8'h0, "");
    n0 = n_strobe;
    fa(1'b0, 7'h08, 8'h0, 8'h00, "absent bank0 08");
    fa(1'b1, 7'h03, 8'h20, 8'h0, "");
    fa(1'b0, 7'h09, 8'h0, 8'h00, "absent bank1 09");
    check("absent strobes", 32'(n_strobe), 32'(n0));
    fa(1'b0, 7'h1F, 8'h0, 8'hC5, "bank1 top sfr");
    fa(1'b1, 7'h20, 8'h99, 8'h0, "");
    fa(1'b1, 7'h03, 8'h60, 8'h0, "");
    fa(1'b0, 7'h20, 8'h0, 8'h99, "bank1 ram base");
    check("sfr strobes", 32'(n_strobe), 32'(n0 + 1));
    fa(1'b1, 7'h0D, 8'h77, 8'h0, "");
    check("peripheral write", 32'(seen_cmd), 32'({1'b1, 9'h18D, 8'h77}));
    $display("test absent locations done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1 check("fetch_pc after second reset", fetch_pc, 13'h0000);
    check("fetch word after second reset", fetch_word, pword(0));
    rdc("latch after second reset", 7'h0A, 32'h0, 1'b0);
    $display("test second reset done");
    summarize();
  end
endmodule
